// [rtl/spifs_clkdiv.v]
// Half-period tick divider for the SPI frame sequencer.
// Assumes one system clock; the tick is a one-cycle enable, never a clock.
`timescale 1ns/1ps
`include "spifs_regs.vh"

module spifs_clkdiv #(
  parameter W = 8
) (
  input wire clk_i, // System clock.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire run_i, // Count while high; held at zero while low.
  input wire [W-1:0] half_i, // Half period in system clocks, zero acts as one.
  output reg tick_o // One-cycle pulse at each half period.
);

  reg [W-1:0] cnt;
  wire [W-1:0] last = (half_i == {W{1'b0}}) ? {W{1'b0}} : half_i - {{(W-1){1'b0}}, 1'b1};

  // Restarting on run low keeps the first half period aligned with the frame start.
  always @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt == last) begin
      cnt <= {W{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end

endmodule // spifs_clkdiv

// [rtl/spifs_regs.vh]
// Register map, field positions, reset values and timing counts of the SPI frame sequencer.
// Included by the sequencer and its half-period divider; holds definitions only.
`ifndef SPIFS_REGS_VH
`define SPIFS_REGS_VH

// Byte offsets of the word-aligned registers on the Avalon-MM slave.
`define SPIFS_ADDR_W 5
`define SPIFS_OFF_CTRL 5'h00
`define SPIFS_OFF_PRESC 5'h04
`define SPIFS_OFF_TX 5'h08
`define SPIFS_OFF_RX 5'h0c
`define SPIFS_OFF_STAT 5'h10

// Control register fields.
`define SPIFS_CTRL_EN 0
`define SPIFS_CTRL_SLAVE 1
`define SPIFS_CTRL_POL 2
`define SPIFS_CTRL_PHA 3
`define SPIFS_CTRL_SIZE_LO 4
`define SPIFS_CTRL_SIZE_HI 7

// Status register fields.
`define SPIFS_STAT_BUSY 0
`define SPIFS_STAT_TXFULL 1
`define SPIFS_STAT_RXVALID 2
`define SPIFS_STAT_FSS 3

// Reset values: disabled master, 8-bit words, half period of ten clocks.
`define SPIFS_CTRL_RST 8'h70
`define SPIFS_PRESC_RST 8'h0a

// Smallest word size code (size code is length minus one, 4 to 16 bits).
`define SPIFS_SIZE_MIN 4'h3

// Half periods from the last clock edge to frame select rising, and of the high gap.
`define SPIFS_TAIL_PH0 2'h1
`define SPIFS_TAIL_PH1 2'h2
`define SPIFS_GAP_HALVES 2'h2

`endif

// [rtl/spifs_sequencer.v]
// SPI frame sequencer: master and slave frame timing in the four polarity/phase modes.
// Assumes an Avalon-MM master on clk_i and asynchronous pins sampled through two flops.
`timescale 1ns/1ps
`include "spifs_regs.vh"

module spifs_sequencer #(
  parameter PRESC_W = 8
) (
  input wire clk_i, // System clock, 20 MHz.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire [`SPIFS_ADDR_W-1:0] address_i, // Avalon byte address.
  input wire read_i, // Avalon read request.
  input wire write_i, // Avalon write request.
  input wire [3:0] byteenable_i, // Avalon byte lanes.
  input wire [31:0] writedata_i, // Avalon write data.
  output reg [31:0] readdata_o, // Avalon read data.
  output reg waitrequest_o, // Avalon wait, high until the answer cycle.
  input wire serial_clock_pin_i, // Serial clock pin level, used in slave role.
  output reg serial_clock_pin_o, // Serial clock driven in master role.
  output reg serial_clock_pin_oe_o, // Serial clock driver enable.
  input wire frame_select_pin_i, // Frame select pin level, active low, slave role.
  output reg frame_select_pin_o, // Frame select driven in master role.
  output reg frame_select_pin_oe_o, // Frame select driver enable.
  input wire serial_in_pin_i, // Serial data from the partner.
  output reg serial_out_pin_o, // Serial data to the partner.
  output reg serial_out_pin_oe_o // Serial data driver enable.
);

  localparam M_IDLE = 3'h0;
  localparam M_LEAD = 3'h1;
  localparam M_SETUP = 3'h2;
  localparam M_CLK = 3'h3;
  localparam M_TAIL = 3'h4;
  localparam M_GAP = 3'h5;

  // Left-aligns a word so that its MSB sits in bit 15.
  function [15:0] align_word;
    input [15:0] word;
    input [3:0] size;
    begin
      align_word = word << (4'hf - size);
    end
  endfunction

  // Keeps only the low size+1 bits of a received word.
  function [15:0] mask_word;
    input [15:0] word;
    input [3:0] size;
    begin
      mask_word = word & ~(16'hfffe << size);
    end
  endfunction

  // Merges write data into a register byte by byte.
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0] be;
    begin
      merge16 = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  reg [7:0] ctrl;
  reg [PRESC_W-1:0] presc;
  reg [15:0] tx_data;
  reg tx_valid;
  reg [15:0] rx_data;
  reg rx_valid;
  reg [2:0] state;
  reg [15:0] tx_sh;
  reg [15:0] rx_sh;
  reg [5:0] edges;
  reg [1:0] halves;
  reg [4:0] sl_bits;
  reg sl_frozen;
  reg sclk_q;
  reg fss_q;
  reg sout_q;
  reg sclk_m1, sclk_s, sclk_d;
  reg fss_m1, fss_s, fss_d;
  reg sin_m1, sin_s;
  wire tick;

  wire en = ctrl[`SPIFS_CTRL_EN];
  wire slave = ctrl[`SPIFS_CTRL_SLAVE];
  wire clock_idle_polarity = ctrl[`SPIFS_CTRL_POL];
  wire clock_phase_select = ctrl[`SPIFS_CTRL_PHA];
  wire [3:0] size_raw = ctrl[`SPIFS_CTRL_SIZE_HI:`SPIFS_CTRL_SIZE_LO];
  wire [3:0] size = (size_raw < `SPIFS_SIZE_MIN) ? `SPIFS_SIZE_MIN : size_raw;
  wire [5:0] last_edge = {1'b0, size, 1'b0} + 6'h2;
  wire [5:0] next_edges = edges + 6'h1;

  // Bus commit happens at the edge where a request sees waitrequest low.
  wire req = read_i | write_i;
  wire commit = req & ~waitrequest_o;
  wire wr_ctrl = commit & write_i & (address_i == `SPIFS_OFF_CTRL);
  wire wr_presc = commit & write_i & (address_i == `SPIFS_OFF_PRESC);
  wire wr_tx = commit & write_i & (address_i == `SPIFS_OFF_TX) & (|byteenable_i[1:0]);
  wire rd_rx = commit & read_i & (address_i == `SPIFS_OFF_RX);

  // Capture edge: phase zero captures odd edges, phase one even edges.
  wire cap_edge = (next_edges[0] == ~clock_phase_select);

  // Slave edge classes: leading moves away from the idle level.
  wire sl_toggle = (sclk_s != sclk_d);
  wire sl_lead = sl_toggle & (sclk_s != clock_idle_polarity);
  wire sl_trail = sl_toggle & (sclk_s == clock_idle_polarity);
  wire sl_cap = clock_phase_select ? sl_trail : sl_lead;
  wire sl_prop = clock_phase_select ? sl_lead : sl_trail;
  wire sl_sel = ~fss_s;
  wire sl_fall = fss_d & ~fss_s;

  spifs_clkdiv #(
    .W(PRESC_W)
  ) u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state != M_IDLE),
    .half_i(presc),
    .tick_o(tick)
  );

  // Pin synchronisers; only the second stage and beyond feed any logic.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_m1 <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      fss_m1 <= 1'b1;
      fss_s <= 1'b1;
      fss_d <= 1'b1;
      sin_m1 <= 1'b0;
      sin_s <= 1'b0;
    end else begin
      sclk_m1 <= serial_clock_pin_i;
      sclk_s <= sclk_m1;
      sclk_d <= sclk_s;
      fss_m1 <= frame_select_pin_i;
      fss_s <= fss_m1;
      fss_d <= fss_s;
      sin_m1 <= serial_in_pin_i;
      sin_s <= sin_m1;
    end
  end

  // Avalon slave: one wait cycle, then a single answer cycle; unmapped reads give zero.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h0;
      ctrl <= `SPIFS_CTRL_RST;
      presc <= `SPIFS_PRESC_RST;
      tx_data <= 16'h0;
    end else begin
      waitrequest_o <= ~(req & waitrequest_o);
      if (req & waitrequest_o) begin
        case (address_i)
          `SPIFS_OFF_CTRL: readdata_o <= {24'h0, ctrl};
          `SPIFS_OFF_PRESC: readdata_o <= {{(32-PRESC_W){1'b0}}, presc};
          `SPIFS_OFF_TX: readdata_o <= {16'h0, tx_data};
          `SPIFS_OFF_RX: readdata_o <= {16'h0, rx_data};
          `SPIFS_OFF_STAT: readdata_o <= {28'h0, fss_s, rx_valid, tx_valid,
                                          (state != M_IDLE) | (slave & en & sl_sel)};
          default: readdata_o <= 32'h0;
        endcase
      end
      if (wr_ctrl && byteenable_i[0]) begin
        ctrl <= writedata_i[7:0];
      end
      if (wr_presc && byteenable_i[0]) begin
        presc <= writedata_i[PRESC_W-1:0];
      end
      // A word written while the holding register is still full is dropped.
      if (wr_tx && !tx_valid) begin
        tx_data <= merge16(tx_data, writedata_i[15:0], byteenable_i[1:0]);
      end
    end
  end

  // Frame engine: master state machine or slave edge follower, plus word hand-off.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= M_IDLE;
      tx_sh <= 16'h0;
      rx_sh <= 16'h0;
      edges <= 6'h0;
      halves <= 2'h0;
      sl_bits <= 5'h0;
      sl_frozen <= 1'b0;
      sclk_q <= 1'b0;
      fss_q <= 1'b1;
      sout_q <= 1'b0;
      tx_valid <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 16'h0;
    end else begin
      // Set wins over clear for rx_valid; tx_valid is set only while empty and cleared only while full.
      if (wr_tx && !tx_valid) begin
        tx_valid <= 1'b1;
      end
      if (rd_rx) begin
        rx_valid <= 1'b0;
      end
      if (!en || slave) begin
        state <= M_IDLE;
        sclk_q <= clock_idle_polarity;
        fss_q <= 1'b1;
        edges <= 6'h0;
      end
      if (en && slave) begin
        if (!sl_sel) begin
          sout_q <= 1'b0;
          sl_bits <= 5'h0;
          sl_frozen <= 1'b0;
        end else if (sl_fall) begin
          sl_bits <= 5'h0;
          sl_frozen <= 1'b0;
          tx_sh <= tx_valid ? align_word(tx_data, size) : 16'h0;
          if (tx_valid) begin
            tx_valid <= 1'b0;
          end
          // Phase zero puts the MSB out before any clock edge arrives.
          if (!clock_phase_select) begin
            sout_q <= tx_valid ? tx_data[size] : 1'b0;
            tx_sh <= tx_valid ? (align_word(tx_data, size) << 1) : 16'h0;
          end
        end else if (!sl_frozen) begin
          if (sl_cap) begin
            rx_sh <= {rx_sh[14:0], sin_s};
            if (sl_bits == {1'b0, size}) begin
              sl_bits <= 5'h0;
              rx_data <= mask_word({rx_sh[14:0], sin_s}, size);
              rx_valid <= 1'b1;
              // Phase zero keeps the shifter frozen until select rises again.
              if (!clock_phase_select) begin
                sl_frozen <= 1'b1;
              end else begin
                tx_sh <= tx_valid ? align_word(tx_data, size) : 16'h0;
                if (tx_valid) begin
                  tx_valid <= 1'b0;
                end
              end
            end else begin
              sl_bits <= sl_bits + 5'h1;
            end
          end else if (sl_prop) begin
            sout_q <= tx_sh[15];
            tx_sh <= tx_sh << 1;
          end
        end
      end else if (en) begin
        case (state)
          M_IDLE: begin
            sout_q <= 1'b0;
            if (tx_valid) begin
              // A frame starts only when enabled with a word waiting.
              tx_sh <= align_word(tx_data, size);
              tx_valid <= 1'b0;
              fss_q <= 1'b0;
              edges <= 6'h0;
              state <= M_LEAD;
            end
          end
          M_LEAD: begin
            if (tick) begin
              sout_q <= tx_sh[15];
              tx_sh <= tx_sh << 1;
              if (clock_phase_select) begin
                // Data and the first clock transition share this moment.
                sclk_q <= ~sclk_q;
                edges <= 6'h1;
                state <= M_CLK;
              end else begin
                state <= M_SETUP;
              end
            end
          end
          M_SETUP: begin
            if (tick) begin
              sclk_q <= ~sclk_q;
              edges <= 6'h1;
              rx_sh <= {rx_sh[14:0], sin_s};
              state <= M_CLK;
            end
          end
          M_CLK: begin
            if (tick) begin
              sclk_q <= ~sclk_q;
              edges <= next_edges;
              if (cap_edge) begin
                rx_sh <= {rx_sh[14:0], sin_s};
                if (next_edges >= last_edge - {5'h0, ~clock_phase_select}) begin
                  rx_data <= mask_word({rx_sh[14:0], sin_s}, size);
                  rx_valid <= 1'b1;
                end
              end else if (next_edges != last_edge) begin
                sout_q <= tx_sh[15];
                tx_sh <= tx_sh << 1;
              end
              if (next_edges == last_edge) begin
                halves <= 2'h0;
                if (clock_phase_select && tx_valid) begin
                  // Phase one runs the next word with select held low.
                  tx_sh <= align_word(tx_data, size);
                  tx_valid <= 1'b0;
                  state <= M_LEAD;
                end else begin
                  state <= M_TAIL;
                end
              end
            end
          end
          M_TAIL: begin
            if (tick) begin
              halves <= halves + 2'h1;
              if (halves + 2'h1 == (clock_phase_select ? `SPIFS_TAIL_PH1 : `SPIFS_TAIL_PH0)) begin
                // Select rises a full clock period after the last capture.
                fss_q <= 1'b1;
                sout_q <= 1'b0;
                halves <= 2'h0;
                state <= M_GAP;
              end
            end
          end
          M_GAP: begin
            // The high gap lets a phase-zero slave reload before the next word.
            if (tick) begin
              halves <= halves + 2'h1;
              if (halves + 2'h1 == `SPIFS_GAP_HALVES) begin
                state <= M_IDLE;
              end
            end
          end
          default: begin
            state <= M_IDLE;
          end
        endcase
      end else begin
        sout_q <= 1'b0;
      end
    end
  end

  // Pin drivers come straight from flops; the clock pad is an input in slave role.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      serial_clock_pin_o <= 1'b0;
      serial_clock_pin_oe_o <= 1'b0;
      frame_select_pin_o <= 1'b1;
      frame_select_pin_oe_o <= 1'b0;
      serial_out_pin_o <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
    end else begin
      serial_clock_pin_o <= sclk_q;
      serial_clock_pin_oe_o <= ~slave;
      frame_select_pin_o <= fss_q;
      frame_select_pin_oe_o <= ~slave;
      serial_out_pin_o <= sout_q;
      serial_out_pin_oe_o <= en & (slave ? sl_sel : 1'b1);
    end
  end

endmodule // spifs_sequencer

// [test/spifs_seq_props.sv]
// Concurrent checks on the pins and bus of the SPI frame sequencer.
// Assumes only the top module's ports; bound into every sequencer instance.
`timescale 1ns/1ps
module spifs_seq_props (
  input wire clk_i, // System clock.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire [4:0] address_i, // Bus address.
  input wire read_i, // Bus read.
  input wire write_i, // Bus write.
  input wire [31:0] readdata_o, // Bus read data.
  input wire waitrequest_o, // Bus wait.
  input wire serial_clock_pin_o, // Clock drive.
  input wire serial_clock_pin_oe_o, // Clock driver enable.
  input wire frame_select_pin_o, // Select drive.
  input wire frame_select_pin_oe_o, // Select driver enable.
  input wire serial_out_pin_o, // Data drive.
  input wire serial_out_pin_oe_o // Data driver enable.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Outside frames the clock holds still; recent writes may retune its idle level.
  chk_idle_clock_still:
    assert property (frame_select_pin_oe_o && frame_select_pin_o && $past(frame_select_pin_o)
      && !$past(write_i) && !$past(write_i, 2) && !$past(write_i, 3)
      |-> $stable(serial_clock_pin_o)) else $error("clock moved while idle");
  chk_idle_out_low:
    assert property (frame_select_pin_oe_o && frame_select_pin_o && $past(frame_select_pin_o)
      && $past(frame_select_pin_o, 2) |-> !serial_out_pin_o) else $error("data high idle");
  chk_drivers_paired:
    assert property (serial_clock_pin_oe_o == frame_select_pin_oe_o)
      else $error("clock driver not following role");
  chk_frame_out_oe:
    assert property (!frame_select_pin_o && frame_select_pin_oe_o |-> serial_out_pin_oe_o)
      else $error("data driver off in frame");
  chk_first_edge_later:
    assert property ($fell(frame_select_pin_o) && frame_select_pin_oe_o
      |=> $stable(serial_clock_pin_o)) else $error("clock edge too soon");
  chk_gap_width:
    assert property ($rose(frame_select_pin_o) && frame_select_pin_oe_o |=> frame_select_pin_o)
      else $error("select gap too short");
  chk_wait_one:
    assert property (!waitrequest_o |=> waitrequest_o) else $error("wait low too long");
  chk_wait_answer:
    assert property ($rose(read_i || write_i) |=> !waitrequest_o) else $error("late answer");
  chk_unmapped_zero:
    assert property (read_i && !waitrequest_o && address_i == 5'h14 |-> readdata_o == 32'h0)
      else $error("unmapped read not zero");
endmodule // spifs_seq_props

bind spifs_sequencer spifs_seq_props spifs_seq_props_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
  .frame_select_pin_o(frame_select_pin_o), .frame_select_pin_oe_o(frame_select_pin_oe_o),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o));

// [test/spifs_spi_model.sv]
// Behavioural off-chip SPI peer used by the master tests of the frame sequencer.
// Assumes resolved pin levels; mode, length and reply word are set by the bench.
`timescale 1ns/1ps
module spifs_spi_model (
  input wire logic sclk_i, // Resolved serial clock.
  input wire logic ss_n_i, // Resolved frame select, active low.
  input wire logic mosi_i, // Data from the sequencer.
  input wire logic pol_i, // Idle clock level.
  input wire logic pha_i, // Clock phase.
  input wire logic [4:0] len_i, // Word length in bits.
  input wire logic [15:0] tx_i, // Reply word.
  output logic miso_o, // Data to the sequencer.
  output logic [15:0] rx_o // Last whole word received.
);
  int cnt;
  logic [15:0] sh;
  logic ss_seen;
  // One process owns the reply line and the bit counter, so each has a single driver.
  always @(ss_n_i or sclk_i) begin
    if (ss_n_i !== ss_seen) begin
      ss_seen = ss_n_i;
      if (!ss_n_i) begin
        // Select fall restarts the word; phase zero puts the MSB out at once.
        cnt = 0;
        if (!pha_i) miso_o = tx_i[len_i-1];
      end else begin
        // A released line shows the inverse of its last value, so a held bit cannot pass.
        miso_o = ~miso_o;
      end
    end else if (!ss_n_i && sclk_i == (pol_i == pha_i)) begin
      // Capture is on the rising edge when polarity equals phase, else on the falling one.
      sh = {sh[14:0], mosi_i};
      cnt = cnt + 1;
      if (cnt == len_i) begin
        rx_o = sh & ((16'h1 << len_i) - 16'h1);
        cnt = 0;
      end
    end else if (!ss_n_i) begin
      miso_o = tx_i[len_i-1-cnt];
    end
  end
endmodule // spifs_spi_model

// [test/testbench.sv]
// Self-checking bench: bus tasks, four master modes against a peer model, one slave run.
// Assumes the sequencer and its divider are compiled first.
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] SIZES [4] = '{4'h3, 4'h7, 4'hf, 4'hb};
  localparam logic [7:0] SDI = 8'h69;
  logic clk_i, rst_n_i, read_i, write_i, tb_sclk, tb_ss, tb_sdi, pol, pha, slv, miso;
  logic waitrequest_o, sclk_o, sclk_oe, ss_o, ss_oe, sdo, sdo_oe, sclk_w, ss_w;
  logic [4:0] address_i, len;
  logic [31:0] writedata_i, readdata_o, q;
  logic [15:0] model_rx, got, mask;
  int miscompares, check_count, rises;
  realtime last_cap;
  // Pins resolve to the driving party; the bench stands in where the design does not drive.
  assign sclk_w = sclk_oe ? sclk_o : tb_sclk;
  assign ss_w = ss_oe ? ss_o : tb_ss;
  spifs_sequencer #(.PRESC_W(8)) spifs_sequencer_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .byteenable_i(4'hf),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe_o(sclk_oe),
    .frame_select_pin_i(ss_w), .frame_select_pin_o(ss_o), .frame_select_pin_oe_o(ss_oe),
    .serial_in_pin_i(slv ? tb_sdi : miso), .serial_out_pin_o(sdo), .serial_out_pin_oe_o(sdo_oe));
  spifs_spi_model spifs_spi_model_i (.sclk_i(sclk_w), .ss_n_i(ss_w), .mosi_i(sdo), .pol_i(pol),
    .pha_i(pha), .len_i(len), .tx_i(16'h5ac3), .miso_o(miso), .rx_o(model_rx));
  // Clock at 20 MHz.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Capture edges are timed so that each master select release can be measured.
  always @(sclk_w) if (!ss_w && sclk_w == (pol == pha)) last_cap = $realtime;
  always @(posedge ss_o) if (ss_oe && !slv && rst_n_i) begin
    rises++;
    chk(int'(($realtime - last_cap) / 50.0), 8, "select release delay");
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One bus access; an edge always passes before a new request so the strobe drops.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 40);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n >= 40) begin
      miscompares++;
      summarize();
    end
  endtask
  // Polls status until the given low bits are clear, under a bound.
  task automatic wait_clear(input logic [31:0] bits);
    int n;
    n = 0;
    do begin
      bus(1'b0, 5'h10, 32'h0);
      n++;
    end while ((q & bits) !== 32'h0 && n < 300);
    if (n >= 300) begin
      miscompares++;
      summarize();
    end
  endtask
  initial begin
    rst_n_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 5'h0;
    writedata_i = 32'h0;
    tb_sclk = 1'b0;
    tb_ss = 1'b1;
    tb_sdi = 1'b0;
    slv = 1'b0;
    pol = 1'b0;
    pha = 1'b0;
    len = 5'h8;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'h70, "control reset value");
    bus(1'b1, 5'h14, 32'hffffffff);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0, "unmapped read");
    // Every polarity and phase, with the shortest and longest word among the sizes.
    for (int m = 0; m < 4; m++) begin
      pol = m[1];
      pha = m[0];
      len = {1'b0, SIZES[m]} + 5'h1;
      mask = (16'h1 << len) - 16'h1;
      bus(1'b1, 5'h00, {24'h0, SIZES[m], pha, pol, 2'b00});
      bus(1'b1, 5'h04, 32'h4);
      chk(sclk_o, pol, "idle clock level");
      chk(sdo, 1'b0, "idle data level");
      chk(sclk_oe, 1'b1, "master clock driver");
      rises = 0;
      bus(1'b1, 5'h08, 32'h9c3a);
      bus(1'b1, 5'h00, {24'h0, SIZES[m], pha, pol, 2'b01});
      wait_clear(32'h2);
      bus(1'b1, 5'h08, 32'h6e95);
      wait_clear(32'h3);
      chk(model_rx, 16'h6e95 & mask, "word seen by peer");
      bus(1'b0, 5'h0c, 32'h0);
      chk(q, {16'h0, 16'h5ac3 & mask}, "word from peer");
      chk(rises, pha ? 1 : 2, "select releases");
      bus(1'b1, 5'h00, {24'h0, SIZES[m], pha, pol, 2'b00});
      $display("Master test in mode %0d done", m);
    end
    // Slave, mode zero, link clock of 400 ns made here; a refill while selected must wait.
    slv <= 1'b1;
    pol <= 1'b0;
    pha <= 1'b0;
    bus(1'b1, 5'h00, 32'h72);
    bus(1'b1, 5'h08, 32'ha5);
    bus(1'b1, 5'h00, 32'h73);
    chk(sclk_oe, 1'b0, "slave clock driver off");
    tb_ss <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(sdo, 1'b1, "slave first bit at select");
    bus(1'b1, 5'h08, 32'hc3); // MSB set, so the later check tells a refill from idle low.
    got = 16'h0;
    for (int i = 7; i >= 0; i--) begin
      tb_sdi <= SDI[i];
      repeat (4) @(posedge clk_i);
      tb_sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      got = {got[14:0], sdo};
      tb_sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    tb_ss <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(got, 16'ha5, "slave shifted word");
    bus(1'b0, 5'h0c, 32'h0);
    chk(q, {24'h0, SDI}, "slave received word");
    tb_ss <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(sdo, 1'b1, "refill loaded after select rise");
    tb_ss <= 1'b1;
    $display("Slave test done");
    summarize();
  end
endmodule // testbench
